// ==== core/codec_power_control_regs.v ====
// codec power control and audio control register bank with apb slave and dac gain stepper
//
// The APB slave port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "codec_pwr_defs.vh"

module codec_power_control_regs (
	input  wire        core_clk_i,
	input  wire        resetn_i,
	// apb slave
	input  wire [7:0]  paddr_i,
	input  wire        psel_i,
	input  wire        penable_i,
	input  wire        pwrite_i,
	input  wire [31:0] pwdata_i,
	output wire [31:0] prdata_o,
	output wire        pready_o,
	output wire        pslverr_o,
	// status from the analog blocks, asynchronous
	input  wire        record_converter_pd_done_i,
	input  wire        left_playback_pd_done_i,
	input  wire        right_playback_pd_done_i,
	input  wire        sidetone_pd_done_i,
	input  wire        mic_gain_done_i,
	input  wire        mic_agc_saturated_i,
	input  wire        mic_agc_en_i,
	input  wire        word_clk_i,
	// power-down and enable controls, applied dac gain and interrupt
	output wire        handset_bias_pd_o,
	output wire        headset_bias_pd_o,
	output wire        sidetone_pd_o,
	output wire        speaker_one_pd_o,
	output wire        speaker_two_pd_o,
	output wire        playback_converter_pd_o,
	output wire        record_converter_pd_o,
	output wire        virtual_ground_pd_o,
	output wire        cell_output_pd_o,
	output wire        loudspeaker_pd_o,
	output wire        codec_full_pd_o,
	output wire        effects_filter_en_o,
	output wire        deemphasis_en_o,
	output wire [7:0]  dac_gain_o,
	output wire        irq_o
);

	// ****************************************************************
	// input synchronisation
	// ****************************************************************

	wire [`SYNC_W-1:0] sync_in;
	wire [`SYNC_W-1:0] raw_in;

	assign raw_in = {
		word_clk_i,
		mic_agc_en_i,
		mic_agc_saturated_i,
		mic_gain_done_i,
		sidetone_pd_done_i,
		right_playback_pd_done_i,
		left_playback_pd_done_i,
		record_converter_pd_done_i
	};

	// the four power-down done flags come out of reset as 1 so the bank reads complete straight away
	status_sync #(
		.WIDTH   (`SYNC_W),
		.RST_VAL (`SYNC_RST)
	) u_status_sync (
		.core_clk_i (core_clk_i),
		.resetn_i   (resetn_i),
		.async_i    (raw_in),
		.sync_o     (sync_in)
	);

	wire       record_pd_done;
	wire       left_pd_done;
	wire       right_pd_done;
	wire       sidetone_done;
	wire       mic_done;
	wire       mic_sat;
	wire       agc_on;
	wire       word_clk;

	assign record_pd_done = sync_in[0];
	assign left_pd_done   = sync_in[1];
	assign right_pd_done  = sync_in[2];
	assign sidetone_done  = sync_in[3];
	assign mic_done       = sync_in[4];
	assign mic_sat        = sync_in[5];
	assign agc_on         = sync_in[6];
	assign word_clk       = sync_in[7];

	// ****************************************************************
	// registers
	// ****************************************************************

	reg [`PD_CTRL_W-1:0] pd_ctrl_reg;
	reg [1:0]            filter_en_reg;
	reg                  soft_step_rate_reg;
	reg [`GAIN_W-1:0]    gain_target_reg;
	reg [`GAIN_W-1:0]    gain_applied_reg;
	reg                  step_phase_reg;
	reg                  word_clk_reg;
	reg [`IRQ_W-1:0]     irq_status_reg;
	reg [`IRQ_W-1:0]     irq_mask_reg;
	reg [`IRQ_W-1:0]     event_level_reg;
	reg                  irq_reg;
	reg                  full_pd_reg;
	reg                  pready_reg;
	reg                  pslverr_reg;
	reg [31:0]           prdata_reg;

	// ****************************************************************
	// apb decode
	// ****************************************************************

	// one wait state: the answer comes on the second access cycle
	wire access;
	wire wr_en;
	wire mapped;
	wire clear_status;

	assign access = psel_i & penable_i & ~pready_reg;
	assign wr_en  = access & pwrite_i & mapped;
	assign mapped = (paddr_i == `AUDIO_CTRL2_ADDR) |
			(paddr_i == `PWR_CTRL_ADDR) |
			(paddr_i == `GAIN_TARGET_ADDR) |
			(paddr_i == `IRQ_STATUS_ADDR) |
			(paddr_i == `IRQ_MASK_ADDR);

	// status word is write-one-to-clear and lives in the interrupt block
	assign clear_status = wr_en & (paddr_i == `IRQ_STATUS_ADDR);

	// ****************************************************************
	// status flags
	// ****************************************************************

	wire mic_flag;
	wire gain_done;

	// agc repurposes the flag as its saturation indicator
	assign mic_flag  = agc_on ? mic_sat : mic_done;
	assign gain_done = (gain_applied_reg == gain_target_reg);

	wire [`IRQ_W-1:0] event_level;
	wire [`IRQ_W-1:0] event_rise;

	// bit order matches the interrupt status word
	assign event_level = {
		gain_done,
		mic_flag,
		sidetone_done,
		right_pd_done,
		left_pd_done,
		record_pd_done
	};
	assign event_rise  = event_level & ~event_level_reg;

	// ****************************************************************
	// read mux
	// ****************************************************************

	reg [31:0] rdata_next;

	always @* begin
		rdata_next = 32'h00000000;
		case (paddr_i)
		`AUDIO_CTRL2_ADDR: begin
			rdata_next[`SOFT_STEP_BIT] = soft_step_rate_reg;
			rdata_next[`MIC_FLAG_BIT]  = mic_flag;
		end
		`PWR_CTRL_ADDR: begin
			rdata_next[`PD_CTRL_MSB:`PD_CTRL_LSB] = pd_ctrl_reg;
			// completion bits always show the live block state
			rdata_next[`PD_DONE_MSB]   = record_pd_done;
			rdata_next[`PD_DONE_MSB-1] = left_pd_done;
			rdata_next[`PD_DONE_MSB-2] = right_pd_done;
			rdata_next[`PD_DONE_LSB]   = sidetone_done;
			rdata_next[`FX_EN_BIT]     = filter_en_reg[`FX_EN_BIT];
			rdata_next[`DEEMPH_EN_BIT] = filter_en_reg[`DEEMPH_EN_BIT];
		end
		`GAIN_TARGET_ADDR: begin
			rdata_next[`GAIN_W-1:0]     = gain_target_reg;
			rdata_next[`GAIN_DONE_BIT]  = gain_done;
			rdata_next[`GAIN_APPLIED_MSB:`GAIN_APPLIED_LSB] = gain_applied_reg;
		end
		`IRQ_STATUS_ADDR: begin
			rdata_next[`IRQ_W-1:0] = irq_status_reg;
		end
		`IRQ_MASK_ADDR: begin
			rdata_next[`IRQ_W-1:0] = irq_mask_reg;
		end
		default: begin
			rdata_next = 32'h00000000;
		end
		endcase
	end

	// ****************************************************************
	// apb answer
	// ****************************************************************

	// read word is captured at the access edge so it stands exactly with pready_o
	always @(posedge core_clk_i) begin
		if (!resetn_i) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h00000000;
		end else begin
			pready_reg  <= access;
			pslverr_reg <= access & ~mapped;
			if (access && !pwrite_i) begin
				prdata_reg <= rdata_next;
			end else if (!access) begin
				prdata_reg <= 32'h00000000;
			end
		end
	end

	// ****************************************************************
	// control registers
	// ****************************************************************

	always @(posedge core_clk_i) begin
		if (!resetn_i) begin
			pd_ctrl_reg        <= `PD_CTRL_RST;
			filter_en_reg      <= `FILTER_EN_RST;
			soft_step_rate_reg <= `SOFT_STEP_RST;
			gain_target_reg    <= `GAIN_RST;
			irq_mask_reg       <= `IRQ_RST;
		end else if (wr_en) begin
			case (paddr_i)
			`AUDIO_CTRL2_ADDR: begin
				// the flag bit is read-only, only the rate select is stored
				soft_step_rate_reg <= pwdata_i[`SOFT_STEP_BIT];
			end
			`PWR_CTRL_ADDR: begin
				pd_ctrl_reg   <= pwdata_i[`PD_CTRL_MSB:`PD_CTRL_LSB];
				filter_en_reg <= pwdata_i[`FX_EN_BIT:`DEEMPH_EN_BIT];
			end
			`GAIN_TARGET_ADDR: begin
				gain_target_reg <= pwdata_i[`GAIN_W-1:0];
			end
			`IRQ_MASK_ADDR: begin
				irq_mask_reg <= pwdata_i[`IRQ_W-1:0];
			end
			default: begin
				// status clears are handled with the interrupt flags
				gain_target_reg <= gain_target_reg;
			end
			endcase
		end
	end

	// ****************************************************************
	// dac gain soft stepping
	// ****************************************************************

	// one code step per word-clock rising edge, or every second edge in slow mode
	// a word clock faster than a few core clocks would lose edges in the synchroniser
	wire wclk_rise;
	wire step_now;

	assign wclk_rise = word_clk & ~word_clk_reg;
	assign step_now  = wclk_rise & (~soft_step_rate_reg | step_phase_reg);

	always @(posedge core_clk_i) begin
		if (!resetn_i) begin
			word_clk_reg     <= 1'b0;
			step_phase_reg   <= 1'b0;
			gain_applied_reg <= `GAIN_RST;
		end else begin
			word_clk_reg <= word_clk;
			if (gain_done) begin
				step_phase_reg <= 1'b0;
			end else if (wclk_rise) begin
				step_phase_reg <= ~step_phase_reg;
			end
			if (step_now && (gain_applied_reg < gain_target_reg)) begin
				gain_applied_reg <= gain_applied_reg + 8'h01;
			end else if (step_now && (gain_applied_reg > gain_target_reg)) begin
				gain_applied_reg <= gain_applied_reg - 8'h01;
			end
		end
	end

	// ****************************************************************
	// full power-down and interrupts
	// ****************************************************************

	always @(posedge core_clk_i) begin
		if (!resetn_i) begin
			full_pd_reg     <= 1'b1;
			event_level_reg <= {`IRQ_W{1'b1}};
			irq_status_reg  <= `IRQ_RST;
			irq_reg         <= 1'b0;
		end else begin
			full_pd_reg     <= &pd_ctrl_reg;
			event_level_reg <= event_level;
			// a new event in the clearing cycle survives the clear
			if (clear_status) begin
				irq_status_reg <= (irq_status_reg & ~pwdata_i[`IRQ_W-1:0]) | event_rise;
			end else begin
				irq_status_reg <= irq_status_reg | event_rise;
			end
			irq_reg <= |(irq_status_reg & irq_mask_reg);
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************

	assign prdata_o                = prdata_reg;
	assign pready_o                = pready_reg;
	assign pslverr_o               = pslverr_reg;
	assign handset_bias_pd_o       = pd_ctrl_reg[`HANDSET_BIAS_POS];
	assign headset_bias_pd_o       = pd_ctrl_reg[`HEADSET_BIAS_POS];
	assign sidetone_pd_o           = pd_ctrl_reg[`SIDETONE_POS];
	assign speaker_one_pd_o        = pd_ctrl_reg[`SPEAKER_ONE_POS];
	assign speaker_two_pd_o        = pd_ctrl_reg[`SPEAKER_TWO_POS];
	assign playback_converter_pd_o = pd_ctrl_reg[`PLAYBACK_POS];
	assign record_converter_pd_o   = pd_ctrl_reg[`RECORD_POS];
	assign virtual_ground_pd_o     = pd_ctrl_reg[`DRIVER_VIRTUAL_GROUND_POS];
	assign cell_output_pd_o        = pd_ctrl_reg[`CELL_OUT_POS];
	assign loudspeaker_pd_o        = pd_ctrl_reg[`LOUDSPEAKER_POS];
	assign codec_full_pd_o         = full_pd_reg;
	assign effects_filter_en_o     = filter_en_reg[`FX_EN_BIT];
	assign deemphasis_en_o         = filter_en_reg[`DEEMPH_EN_BIT];
	assign dac_gain_o              = gain_applied_reg;
	assign irq_o                   = irq_reg;

endmodule

`default_nettype wire

// ==== core/codec_pwr_defs.vh ====
// register map, field positions, reset values and timing for the codec power control bank
`ifndef CODEC_PWR_DEFS_VH
`define CODEC_PWR_DEFS_VH

// register indices as printed; byte address is four times the index
`define AUDIO_CTRL2_IDX       8'h04
`define PWR_CTRL_IDX          8'h05
`define GAIN_TARGET_IDX       8'h08
`define IRQ_STATUS_IDX        8'h10
`define IRQ_MASK_IDX          8'h11

`define AUDIO_CTRL2_ADDR      8'h10
`define PWR_CTRL_ADDR         8'h14
`define GAIN_TARGET_ADDR      8'h20
`define IRQ_STATUS_ADDR       8'h40
`define IRQ_MASK_ADDR         8'h44

// audio control two, low bits
`define SOFT_STEP_BIT         1
`define MIC_FLAG_BIT          0
`define SOFT_STEP_RST         1'h0

// power control fields
`define PD_CTRL_MSB           15
`define PD_CTRL_LSB           6
`define PD_CTRL_W             10
`define PD_CTRL_RST           10'h3FF
`define PD_DONE_MSB           5
`define PD_DONE_LSB           2
`define PD_DONE_RST           4'hF
`define FX_EN_BIT             1
`define DEEMPH_EN_BIT         0
`define FILTER_EN_RST         2'h0

// positions inside the power-down control field
`define HANDSET_BIAS_POS      9
`define HEADSET_BIAS_POS      8
`define SIDETONE_POS          7
`define SPEAKER_ONE_POS       6
`define SPEAKER_TWO_POS       5
`define PLAYBACK_POS          4
`define RECORD_POS            3
`define DRIVER_VIRTUAL_GROUND_POS              2
`define CELL_OUT_POS          1
`define LOUDSPEAKER_POS       0

// dac gain stepping, one code is 0.5 dB
`define GAIN_W                8
`define GAIN_RST              8'h00
`define GAIN_DONE_BIT         8
`define GAIN_APPLIED_MSB      23
`define GAIN_APPLIED_LSB      16
`define SLOW_STEP_PERIODS     2'h2

// interrupt events
`define IRQ_W                 6
`define IRQ_RECORD_PD         0
`define IRQ_LEFT_PD           1
`define IRQ_RIGHT_PD          2
`define IRQ_SIDETONE_PD       3
`define IRQ_MIC_FLAG          4
`define IRQ_DAC_GAIN          5
`define IRQ_RST               6'h00

// synchronised inputs
`define SYNC_W                8
`define SYNC_RST              8'h0F

`endif

// ==== core/status_sync.v ====
// two flip-flop synchroniser for a group of level inputs
`timescale 1ns/100ps
`default_nettype none

module status_sync #(
	parameter        WIDTH   = 1,
	parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
	input  wire             core_clk_i,
	input  wire             resetn_i,
	input  wire [WIDTH-1:0] async_i,
	output wire [WIDTH-1:0] sync_o
);

	reg [WIDTH-1:0] meta_reg;
	reg [WIDTH-1:0] sync_reg;

	// first stage feeds only the second stage
	always @(posedge core_clk_i) begin
		if (!resetn_i) begin
			meta_reg <= RST_VAL;
			sync_reg <= RST_VAL;
		end else begin
			meta_reg <= async_i;
			sync_reg <= meta_reg;
		end
	end

	assign sync_o = sync_reg;

endmodule

`default_nettype wire

// ==== verification/codec_power_control_regs_checker.sv ====
// concurrent checks on the ports of the codec power control register bank
`timescale 1ns/100ps
`default_nettype none

module codec_power_control_regs_checker (
	input wire logic        core_clk_i,
	input wire logic        resetn_i,
	input wire logic [7:0]  paddr_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [31:0] prdata_o,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	input wire logic [9:0]  pd_v,
	input wire logic        codec_full_pd_o,
	input wire logic [7:0]  dac_gain_o
);
	// ****************************************
	// helpers
	// ****************************************
	wire logic access = psel_i && penable_i && !pready_o;
	wire logic mapped = paddr_i == 8'h10 || paddr_i == 8'h14 || paddr_i == 8'h20 || paddr_i == 8'h40 || paddr_i == 8'h44;
	wire logic wr_pwr = psel_i && penable_i && pwrite_i && pready_o && paddr_i == 8'h14;
	wire logic all_pd = &pd_v;

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!resetn_i);

	sequence s_step;
		$changed(dac_gain_o);
	endsequence

	// ****************************************
	// assertions
	// ****************************************
	a_ready_pulse: assert property (pready_o |=> !pready_o)
		else $error("pready held longer than one cycle");
	a_ready_timing: assert property (access |=> pready_o)
		else $error("pready not one cycle after access");
	a_err_unmapped: assert property (access && !mapped |=> pslverr_o)
		else $error("no error for unmapped address");
	a_err_mapped: assert property (access && mapped |=> !pslverr_o)
		else $error("error on mapped address");
	a_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h00000000)
		else $error("read data not zero outside answer");
	a_full_on: assert property (all_pd && $past(all_pd) |-> codec_full_pd_o)
		else $error("full power-down missing");
	a_full_off: assert property (!all_pd && !$past(all_pd) |-> !codec_full_pd_o)
		else $error("full power-down without all bits");
	// the control word lands at the access edge, so the outputs move in the answer cycle
	a_pd_by_write: assert property ($changed(pd_v) |-> wr_pwr)
		else $error("power-down output changed without write");
	a_gain_unit: assert property (s_step |->
			dac_gain_o - $past(dac_gain_o) == 8'h01 || $past(dac_gain_o) - dac_gain_o == 8'h01)
		else $error("gain step not one code");
	a_gain_spacing: assert property (s_step |=> $stable(dac_gain_o)[*5])
		else $error("gain steps closer than a word clock");
endmodule

`default_nettype wire

// ==== verification/codec_power_control_regs_tb_top.sv ====
// self-checking testbench for the codec power control register bank
`timescale 1ns/100ps
`default_nettype none

`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
	$display("ERROR t=%0t got=%0h exp=%0h", $time, a, e); end end

module codec_power_control_regs_tb_top;
	logic        core_clk_i = 1'b0;
	logic        resetn_i   = 1'b0;
	logic [7:0]  paddr      = 8'h00;
	logic        psel       = 1'b0;
	logic        penable    = 1'b0;
	logic        pwrite     = 1'b0;
	logic [31:0] pwdata     = 32'h00000000;
	logic [3:0]  done_v     = 4'hF;
	logic [2:0]  mic_v      = 3'h0;
	logic [2:0]  wcnt       = 3'h0;
	wire  [31:0] prdata;
	wire         pready;
	wire         pslverr;
	wire  [9:0]  pd_v;
	wire         full_pd;
	wire         fx_en;
	wire         de_en;
	wire  [7:0]  gain;
	wire         irq;
	int          n_mismatch = 0;
	int          checked    = 0;
	int          k;
	int          e;
	logic [31:0] rd;
	logic        err;
	logic [9:0]  m;

	always #5 core_clk_i = ~core_clk_i;
	// word clock period of eight core clocks keeps the stepper's sampling margin
	always @(posedge core_clk_i) wcnt <= wcnt + 3'h1;

	codec_power_control_regs codec_power_control_regs_i (
		.core_clk_i(core_clk_i), .resetn_i(resetn_i), .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.record_converter_pd_done_i(done_v[3]), .left_playback_pd_done_i(done_v[2]),
		.right_playback_pd_done_i(done_v[1]), .sidetone_pd_done_i(done_v[0]), .mic_gain_done_i(mic_v[0]),
		.mic_agc_saturated_i(mic_v[1]), .mic_agc_en_i(mic_v[2]), .word_clk_i(wcnt[2]),
		.handset_bias_pd_o(pd_v[9]), .headset_bias_pd_o(pd_v[8]), .sidetone_pd_o(pd_v[7]),
		.speaker_one_pd_o(pd_v[6]), .speaker_two_pd_o(pd_v[5]), .playback_converter_pd_o(pd_v[4]),
		.record_converter_pd_o(pd_v[3]), .virtual_ground_pd_o(pd_v[2]), .cell_output_pd_o(pd_v[1]),
		.loudspeaker_pd_o(pd_v[0]), .codec_full_pd_o(full_pd), .effects_filter_en_o(fx_en),
		.deemphasis_en_o(de_en), .dac_gain_o(gain), .irq_o(irq));

	// ****************************************
	// tasks
	// ****************************************
	task automatic final_report;
		if (n_mismatch == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge core_clk_i);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge core_clk_i);
		penable <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge core_clk_i);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k == 50) begin
			n_mismatch++;
			final_report;
		end
	endtask

	task automatic settle;
		repeat (4) @(posedge core_clk_i);
	endtask

	// counts raw word clock rises until the applied gain reaches t
	task automatic wait_gain(input logic [7:0] t);
		e = 0;
		for (k = 0; k < 400 && gain !== t; k++) begin
			@(posedge core_clk_i);
			if (wcnt == 3'h3)
				e++;
		end
		if (k == 400) begin
			n_mismatch++;
			final_report;
		end
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (8) @(posedge core_clk_i);
		resetn_i <= 1'b1;
		settle;
		`CHK({pd_v, full_pd, fx_en, de_en, gain, irq}, {10'h3FF, 3'h4, 8'h00, 1'b0})
		apb(8'h14, 1'b0, 32'h00000000);
		`CHK(rd, 32'h0000FFFC)
		for (int i = 0; i < 4; i++) begin
			done_v <= ~(4'h1 << i);
			settle;
			apb(8'h14, 1'b0, 32'h00000000);
			`CHK(rd, {16'h0000, 10'h3FF, ~(4'h1 << i), 2'h0})
			done_v <= 4'hF;
			settle;
		end
		`CHK(irq, 1'b0)
		apb(8'h40, 1'b0, 32'h00000000);
		`CHK(rd & 32'h0000000F, 32'h0000000F)
		apb(8'h44, 1'b1, 32'h00000001);
		settle;
		`CHK(irq, 1'b1)
		apb(8'h40, 1'b1, 32'h0000003F);
		settle;
		`CHK(irq, 1'b0)
		apb(8'h40, 1'b0, 32'h00000000);
		`CHK(rd & 32'h0000000F, 32'h00000000)
		for (int i = 0; i < 8; i++) begin
			mic_v <= i[2:0];
			settle;
			apb(8'h10, 1'b0, 32'h00000000);
			`CHK(rd, {31'h0, i[2] ? i[1] : i[0]})
		end
		mic_v <= 3'h0;
		for (int i = 0; i < 10; i++) begin
			m = 10'h3FF ^ (10'h001 << i);
			apb(8'h14, 1'b1, {16'h0000, m, 4'h0, 2'h3});
			settle;
			`CHK({pd_v, full_pd, fx_en, de_en}, {m, 3'h3})
			apb(8'h14, 1'b0, 32'h00000000);
			`CHK(rd, {16'h0000, m, 4'hF, 2'h3})
		end
		apb(8'h14, 1'b1, 32'h0000FFC1);
		settle;
		`CHK({full_pd, fx_en, de_en}, 3'h5)
		apb(8'h14, 1'b1, 32'h0000FFC2);
		settle;
		`CHK({full_pd, fx_en, de_en}, 3'h6)
		apb(8'h20, 1'b1, 32'h00000004);
		wait_gain(8'h04);
		`CHK(e >= 3 && e <= 5, 1'b1)
		settle;
		apb(8'h20, 1'b0, 32'h00000000);
		`CHK(rd, 32'h00040104)
		apb(8'h10, 1'b1, 32'h00000003);
		apb(8'h10, 1'b0, 32'h00000000);
		`CHK(rd, 32'h00000002)
		apb(8'h20, 1'b1, 32'h00000000);
		wait_gain(8'h00);
		`CHK(e >= 7 && e <= 9, 1'b1)
		apb(8'h3C, 1'b1, 32'hFFFFFFFF);
		`CHK(err, 1'b1)
		apb(8'h3C, 1'b0, 32'h00000000);
		`CHK({err, rd}, {1'b1, 32'h00000000})
		apb(8'h44, 1'b0, 32'h00000000);
		`CHK({err, rd}, {1'b0, 32'h00000001})
		final_report;
	end
endmodule

bind codec_power_control_regs codec_power_control_regs_checker chk_i (
	.core_clk_i(core_clk_i), .resetn_i(resetn_i), .paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i),
	.pwrite_i(pwrite_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
	.pd_v({handset_bias_pd_o, headset_bias_pd_o, sidetone_pd_o, speaker_one_pd_o, speaker_two_pd_o,
		playback_converter_pd_o, record_converter_pd_o, virtual_ground_pd_o, cell_output_pd_o, loudspeaker_pd_o}),
	.codec_full_pd_o(codec_full_pd_o), .dac_gain_o(dac_gain_o));

`default_nettype wire
